// ===== design/spm_spi_master.sv
`timescale 1ns/1ns
module spm_spi_master
    import spm_pkg::*;
(
    input  wire logic        pclk,              // system clock
    input  wire logic        presetn,           // async reset, active low
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb enable
    input  wire logic        pwrite,            // apb direction
    input  wire logic [15:0] paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error
    output logic             serial_clock_out,  // serial clock
    output logic             serial_data_out,   // transmit line
    input  wire logic        serial_data_in,    // receive line
    output logic [3:0]       slave_select_out,  // four selects
    output logic             char_irq           // character-done pulse
);

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [15:0]  div_q;
    logic [15:0]  ctl_q;
    logic [15:0]  sel_lo_q;
    logic [15:0]  sel_hi_q;
    logic [15:0]  cmd_lo_q;
    logic [15:0]  cmd_hi_q;
    logic [31:0]  tx_q;
    logic [31:0]  rx_q;
    logic [31:0]  prdata_q;
    logic         char_done_q;
    logic         char_done_d;
    logic         frame_done_q;
    logic         frame_done_d;
    logic         irq_q;

    // engine state
    spm_state_t   state_q;
    spm_state_t   state_d;
    logic [15:0]  hcnt_q;
    logic [15:0]  hcnt_d;
    logic [2:0]   lead_q;
    logic [2:0]   lead_d;
    logic         sclk_q;
    logic         sclk_d;
    logic         mosi_q;
    logic         mosi_d;
    logic [4:0]   bidx_q;
    logic [4:0]   bidx_d;
    logic [31:0]  sh_q;
    logic [31:0]  sh_d;
    logic [31:0]  rsh_q;
    logic [31:0]  rsh_d;
    logic [31:0]  rx_d;
    logic [11:0]  left_q;
    logic [11:0]  left_d;
    logic [1:0]   asel_q;
    logic [1:0]   asel_d;
    logic [4:0]   alen_q;
    logic [4:0]   alen_d;
    spm_sel_cfg_t acfg_q;
    spm_sel_cfg_t acfg_d;
    logic         char_end;
    logic         frame_end;
    logic         rx_s1_q;
    logic         rx_s2_q;
    logic [3:0]   ss_q;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; word index from the byte address
    wire [13:0] widx      = paddr[15:2];
    wire        aligned   = (paddr[1:0] == 2'b00);
    wire        hit_div   = aligned && (widx == SPM_IDX_CLK_DIV);
    wire        hit_ctl   = aligned && (widx == SPM_IDX_CLK_CTL);
    wire        hit_sello = aligned && (widx == SPM_IDX_SEL_LO);
    wire        hit_selhi = aligned && (widx == SPM_IDX_SEL_HI);
    wire        hit_cmdlo = aligned && (widx == SPM_IDX_CMD_LO);
    wire        hit_cmdhi = aligned && (widx == SPM_IDX_CMD_HI);
    wire        hit_stlo  = aligned && (widx == SPM_IDX_STAT_LO);
    wire        hit_sthi  = aligned && (widx == SPM_IDX_STAT_HI);
    wire        hit_datlo = aligned && (widx == SPM_IDX_DAT_LO);
    wire        hit_dathi = aligned && (widx == SPM_IDX_DAT_HI);
    wire        mapped    = hit_div | hit_ctl | hit_sello | hit_selhi |
                            hit_cmdlo | hit_cmdhi | hit_stlo | hit_sthi |
                            hit_datlo | hit_dathi;
    wire        setup_rd  = psel && !penable && !pwrite;
    wire        acc       = psel && penable;
    wire        wr_ok     = acc && pwrite && mapped;
    wire        rd_ok     = acc && !pwrite && mapped;
    wire [15:0] wlo       = pwdata[15:0];

    // zero-wait slave; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = prdata_q;

    // status read clears the sticky flags at the completing edge
    wire clr_flags = rd_ok && hit_stlo;
    wire busy      = (state_q != SPM_ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // read mux: sixteen-bit registers sit in the low half
    logic [15:0] rmux;
    wire  [15:0] stat_lo = {13'h0000, frame_done_q, char_done_q, busy};
    wire  [15:0] stat_hi = {4'h0, left_q};
    wire  [15:0] cmd_hi_rd = {1'b0, cmd_hi_q[14:0]};
    assign rmux = hit_div   ? div_q     :
                  hit_ctl   ? ctl_q     :
                  hit_sello ? sel_lo_q  :
                  hit_selhi ? sel_hi_q  :
                  hit_cmdlo ? cmd_lo_q  :
                  hit_cmdhi ? cmd_hi_rd :
                  hit_stlo  ? stat_lo   :
                  hit_sthi  ? stat_hi   :
                  hit_datlo ? rx_q[15:0] :
                  hit_dathi ? rx_q[31:16] :
                  SPM_RST_REG;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= SPM_RST_WORD;
        end else if (setup_rd) begin
            prdata_q <= {16'h0000, rmux};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-written registers; data moves only by cpu access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q    <= SPM_RST_REG;
            ctl_q    <= SPM_RST_REG;
            sel_lo_q <= SPM_RST_REG;
            sel_hi_q <= SPM_RST_REG;
            cmd_lo_q <= SPM_RST_REG;
            cmd_hi_q <= SPM_RST_REG;
            tx_q     <= SPM_RST_WORD;
        end else if (wr_ok) begin
            if (hit_div)   div_q           <= wlo;
            if (hit_ctl)   ctl_q           <= wlo;
            if (hit_sello) sel_lo_q        <= wlo;
            if (hit_selhi) sel_hi_q        <= wlo;
            if (hit_cmdlo) cmd_lo_q        <= wlo;
            if (hit_cmdhi) cmd_hi_q        <= wlo;
            if (hit_datlo) tx_q[15:0]      <= wlo;
            if (hit_dathi) tx_q[31:16]     <= wlo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration views; a new command uses the value being written
    wire [31:0]   sel_all  = {sel_hi_q, sel_lo_q};
    wire [15:0]   cmd_new  = wlo;
    wire [1:0]    new_sel  = cmd_new[SPM_CMD_SEL_LSB +: 2];
    wire [4:0]    new_len  = cmd_new[SPM_CMD_LEN_LSB +: SPM_LEN_W];
    wire [1:0]    cur_sel  = cmd_hi_q[SPM_CMD_SEL_LSB +: 2];
    wire spm_sel_cfg_t new_cfg =
        spm_sel_cfg_t'(sel_all[SPM_SEL_CFG_W*new_sel +: SPM_SEL_FLD_W]);
    wire spm_sel_cfg_t cur_cfg =
        spm_sel_cfg_t'(sel_all[SPM_SEL_CFG_W*cur_sel +: SPM_SEL_FLD_W]);
    wire          start    = wr_ok && hit_cmdhi &&
                             cmd_new[SPM_CMD_START_BIT] && !busy;
    wire          loopback = ctl_q[SPM_CTL_LOOP_BIT];

    // half period clamped: period stays above four clocks and the
    // synchronised receive bit has settled before it is sampled
    wire [15:0] half    = (div_q < SPM_MIN_HALF) ? SPM_MIN_HALF : div_q;
    wire [15:0] half_m1 = half - 16'h0001;
    wire        tick    = (hcnt_q == 16'h0000);
    wire        leading = (sclk_q == acfg_q.cpol);
    // loopback ignores the pin entirely
    wire        rx_bit  = loopback ? mosi_q : rx_s2_q;
    wire [2:0]  lead_last = {acfg_q.dly, 1'b0};
    wire [31:0] rsh_in  = {rsh_q[30:0], rx_bit};

    ////////////////////////////////////////////////////////////////////////
    // receive pin synchroniser; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
        end else begin
            rx_s1_q <= serial_data_in;
            rx_s2_q <= rx_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engine next state
    always_comb begin
        state_d   = state_q;
        lead_d    = lead_q;
        sclk_d    = sclk_q;
        mosi_d    = mosi_q;
        bidx_d    = bidx_q;
        sh_d      = sh_q;
        rsh_d     = rsh_q;
        rx_d      = rx_q;
        left_d    = left_q;
        asel_d    = asel_q;
        alen_d    = alen_q;
        acfg_d    = acfg_q;
        char_end  = 1'b0;
        frame_end = 1'b0;
        // divider runs freely only inside a frame
        hcnt_d    = (state_q == SPM_ST_IDLE || tick) ? half_m1
                                                     : hcnt_q - 16'h0001;
        unique case (state_q)
            SPM_ST_IDLE: begin
                sclk_d = cur_cfg.cpol;
                if (start) begin
                    asel_d  = new_sel;
                    alen_d  = new_len;
                    acfg_d  = new_cfg;
                    left_d  = cmd_lo_q[SPM_CMD_FRAME_LSB +: SPM_FRAME_W];
                    sclk_d  = new_cfg.cpol;
                    sh_d    = tx_q;
                    bidx_d  = new_len;
                    mosi_d  = tx_q[new_len];
                    rsh_d   = SPM_RST_WORD;
                    lead_d  = 3'b000;
                    state_d = SPM_ST_LEAD;
                end
            end
            SPM_ST_LEAD: begin
                // first edge one period plus delay after select; the
                // last half period of that is the first tick of SHIFT
                if (tick) begin
                    lead_d = lead_q + 3'b001;
                    if (lead_q == lead_last) begin
                        state_d = SPM_ST_SHIFT;
                    end
                end
            end
            SPM_ST_SHIFT: begin
                if (tick) begin
                    sclk_d = ~sclk_q;
                    if (leading) begin
                        if (acfg_q.cpha) begin
                            mosi_d = sh_q[bidx_q];
                        end else begin
                            rsh_d = rsh_in;
                        end
                    end else begin
                        if (acfg_q.cpha) begin
                            rsh_d = rsh_in;
                        end
                        if (bidx_q == 5'd0) begin
                            char_end = 1'b1;
                            rx_d     = acfg_q.cpha ? rsh_in : rsh_q;
                            if (left_q == 12'h000) begin
                                state_d = SPM_ST_TRAIL;
                            end else begin
                                // next character follows without a gap
                                left_d = left_q - 12'h001;
                                sh_d   = tx_q;
                                bidx_d = alen_q;
                                rsh_d  = SPM_RST_WORD;
                                if (!acfg_q.cpha) begin
                                    mosi_d = tx_q[alen_q];
                                end
                            end
                        end else begin
                            bidx_d = bidx_q - 5'd1;
                            if (!acfg_q.cpha) begin
                                mosi_d = sh_q[bidx_q - 5'd1];
                            end
                        end
                    end
                end
            end
            SPM_ST_TRAIL: begin
                // select stays active one half period past the last edge
                if (tick) begin
                    frame_end = 1'b1;
                    state_d   = SPM_ST_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engine registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SPM_ST_IDLE;
            hcnt_q  <= SPM_RST_REG;
            lead_q  <= 3'b000;
            sclk_q  <= 1'b0;
            mosi_q  <= 1'b0;
            bidx_q  <= 5'd0;
            sh_q    <= SPM_RST_WORD;
            rsh_q   <= SPM_RST_WORD;
            rx_q    <= SPM_RST_WORD;
            left_q  <= 12'h000;
            asel_q  <= 2'b00;
            alen_q  <= 5'd0;
            acfg_q  <= '0;
        end else begin
            state_q <= state_d;
            hcnt_q  <= hcnt_d;
            lead_q  <= lead_d;
            sclk_q  <= sclk_d;
            mosi_q  <= mosi_d;
            bidx_q  <= bidx_d;
            sh_q    <= sh_d;
            rsh_q   <= rsh_d;
            rx_q    <= rx_d;
            left_q  <= left_d;
            asel_q  <= asel_d;
            alen_q  <= alen_d;
            acfg_q  <= acfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status flags; a new event beats a clearing read
    // only a flag that the read returned set is cleared, so an event
    // landing between setup and access is not lost
    wire clr_char  = clr_flags && prdata_q[SPM_ST_CHAR_BIT];
    wire clr_frame = clr_flags && prdata_q[SPM_ST_FRAME_BIT];
    assign char_done_d  = char_end  | (char_done_q  & ~clr_char);
    assign frame_done_d = frame_end | (frame_done_q & ~clr_frame);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            char_done_q  <= 1'b0;
            frame_done_q <= 1'b0;
            irq_q        <= 1'b0;
        end else begin
            char_done_q  <= char_done_d;
            frame_done_q <= frame_done_d;
            irq_q        <= char_end && cmd_lo_q[SPM_CMD_IRQ_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // select outputs; unselected ones rest at their own inactive level
    genvar gi;
    generate
        for (gi = 0; gi < SPM_NUM_SEL; gi++) begin : g_sel
            wire spm_sel_cfg_t own_cfg =
                spm_sel_cfg_t'(sel_all[SPM_SEL_CFG_W*gi +: SPM_SEL_FLD_W]);
            wire act = (state_d != SPM_ST_IDLE) && (asel_d == 2'(gi));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ss_q[gi] <= 1'b1;
                end else begin
                    ss_q[gi] <= act ? acfg_d.cs_high : ~own_cfg.cs_high;
                end
            end
        end
    endgenerate

    // all pin outputs straight from flops
    assign slave_select_out = ss_q;
    assign serial_clock_out = sclk_q;
    assign serial_data_out  = mosi_q;
    assign char_irq         = irq_q;

endmodule // spm_spi_master

// ===== design/spm_pkg.sv
package spm_pkg;

    // register indices; byte address on the bus is four times the index
    localparam int unsigned SPM_ADDR_W       = 16;
    localparam int unsigned SPM_IDX_W        = 14;
    localparam logic [13:0] SPM_IDX_CLK_DIV  = 14'h3000;
    localparam logic [13:0] SPM_IDX_CLK_CTL  = 14'h3001;
    localparam logic [13:0] SPM_IDX_SEL_LO   = 14'h3002;
    localparam logic [13:0] SPM_IDX_SEL_HI   = 14'h3003;
    localparam logic [13:0] SPM_IDX_CMD_LO   = 14'h3004;
    localparam logic [13:0] SPM_IDX_CMD_HI   = 14'h3005;
    localparam logic [13:0] SPM_IDX_STAT_LO  = 14'h3006;
    localparam logic [13:0] SPM_IDX_STAT_HI  = 14'h3007;
    localparam logic [13:0] SPM_IDX_DAT_LO   = 14'h3008;
    localparam logic [13:0] SPM_IDX_DAT_HI   = 14'h3009;

    localparam int unsigned SPM_REG_W        = 16;
    localparam int unsigned SPM_DATA_W       = 32;
    localparam int unsigned SPM_NUM_SEL      = 4;
    localparam int unsigned SPM_SEL_CFG_W    = 8;
    localparam int unsigned SPM_LEN_W        = 5;
    localparam int unsigned SPM_FRAME_W      = 12;

    // reset values
    localparam logic [15:0] SPM_RST_REG      = 16'h0000;
    localparam logic [31:0] SPM_RST_WORD     = 32'h0000_0000;

    // divider: half serial period in system clocks, never below three;
    // the receive synchroniser needs two clocks after each launch edge
    localparam logic [15:0] SPM_MIN_HALF     = 16'h0003;

    // serial_clock_control fields
    localparam int unsigned SPM_CTL_LOOP_BIT = 0;

    // transfer_command_low fields
    localparam int unsigned SPM_CMD_FRAME_LSB = 0;
    localparam int unsigned SPM_CMD_IRQ_BIT   = 14;

    // transfer_command_high fields
    localparam int unsigned SPM_CMD_LEN_LSB   = 0;
    localparam int unsigned SPM_CMD_SEL_LSB   = 8;
    localparam int unsigned SPM_CMD_START_BIT = 15;

    // port_status_low fields
    localparam int unsigned SPM_ST_BUSY_BIT   = 0;
    localparam int unsigned SPM_ST_CHAR_BIT   = 1;
    localparam int unsigned SPM_ST_FRAME_BIT  = 2;

    // per-select configuration, one byte each, low five bits used
    typedef struct packed {
        logic [1:0] dly;       // select-to-data delay in serial periods
        logic       cs_high;   // 1: select is active high
        logic       cpol;      // clock polarity
        logic       cpha;      // clock phase
    } spm_sel_cfg_t;

    localparam int unsigned SPM_SEL_FLD_W = $bits(spm_sel_cfg_t);

    typedef enum logic [1:0] {
        SPM_ST_IDLE  = 2'b00,
        SPM_ST_LEAD  = 2'b01,
        SPM_ST_SHIFT = 2'b10,
        SPM_ST_TRAIL = 2'b11
    } spm_state_t;

endpackage

// ===== dv/spm_spi_master_checker.sv
`timescale 1ns/1ns
module spm_spi_master_checker
    import spm_pkg::*;
(
    input wire logic        pclk,             // clock
    input wire logic        presetn,          // reset
    input wire logic        psel,             // bus select
    input wire logic        penable,          // bus enable
    input wire logic        pwrite,           // bus direction
    input wire logic [15:0] paddr,            // bus address
    input wire logic [31:0] pwdata,           // bus data
    input wire logic        pready,           // bus ready
    input wire logic        pslverr,          // bus error
    input wire logic        serial_clock_out, // serial clock
    input wire logic        serial_data_out,  // transmit line
    input wire logic [3:0]  slave_select_out, // selects
    input wire logic        char_irq          // char pulse
);
    logic [3:0] pol_n;
    logic [3:0] pol_q;
    logic [3:0] act;
    logic       wr_lo;
    logic       wr_hi;
    logic       any;
    // polarity shadow, delayed a cycle so it changes with the pins
    assign wr_lo = psel && penable && pwrite && paddr[15:2] == SPM_IDX_SEL_LO;
    assign wr_hi = psel && penable && pwrite && paddr[15:2] == SPM_IDX_SEL_HI;
    assign act   = ~(slave_select_out ^ pol_q);
    assign any   = |act;
    // active-high bit of each select byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_n <= 4'h0;
            pol_q <= 4'h0;
        end else begin
            pol_q <= pol_n;
            if (wr_lo) pol_n[1:0] <= {pwdata[10], pwdata[2]};
            else if (wr_hi) pol_n[3:2] <= {pwdata[10], pwdata[2]};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (psel |-> pready)
        else $error("pready low in transfer");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_one_select: assert property ($countones(act) <= 1)
        else $error("more than one select active");
    a_half_min: assert property (
        $changed(serial_clock_out) |=> $stable(serial_clock_out) [*2])
        else $error("serial clock half period too short");
    a_idle_rest: assert property (
        !any && !$past(psel) && !$past(psel, 2)
        |-> $stable(serial_clock_out))
        else $error("serial clock moved with no select");
    a_irq_pulse: assert property (char_irq |=> !char_irq)
        else $error("char_irq longer than one cycle");
    a_tx_launch: assert property (
        any && $past(any) && $changed(serial_data_out)
        |-> $changed(serial_clock_out))
        else $error("transmit line moved off a clock edge");
    a_lead_wait: assert property (
        $rose(any) |=> $stable(serial_clock_out) [*3])
        else $error("clock edge too soon after select");
    a_trail_hold: assert property (
        $fell(any) |-> $stable(serial_clock_out)
        && $past(serial_clock_out, 2) == serial_clock_out)
        else $error("select released too soon after last edge");
endmodule // spm_spi_master_checker

bind spm_spi_master spm_spi_master_checker i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_out(serial_clock_out),
    .serial_data_out(serial_data_out),
    .slave_select_out(slave_select_out), .char_irq(char_irq)
);

// ===== dv/spm_slave_model.sv
`timescale 1ns/1ns
module spm_slave_model (
    input  wire logic        sclk,    // serial clock
    input  wire logic        cs_n,    // select, low active
    input  wire logic        mosi,    // from master
    input  wire logic        cpol,    // clock polarity
    input  wire logic        cpha,    // clock phase
    input  wire logic [31:0] tx_word, // reply, msb first
    output logic             miso,    // to master
    output logic      [31:0] rx_word  // bits seen, newest lowest
);
    logic [31:0] sh;
    initial miso = 1'b0;
    // frame start: phase 0 presents the first bit with the select
    always @(negedge cs_n) begin
        sh = tx_word;
        rx_word = 32'h0;
        if (!cpha) begin
            miso = sh[31];
            sh = sh << 1;
        end
    end
    // released line must not keep its last bit
    always @(posedge cs_n) miso = ~miso;
    // sample on the mode's sampling edge, launch on the other
    always @(sclk) begin
        if (!cs_n && ((sclk != cpol) ^ cpha)) begin
            rx_word = {rx_word[30:0], mosi};
        end else if (!cs_n) begin
            miso = sh[31];
            sh = sh << 1;
        end
    end
endmodule // spm_slave_model

// ===== dv/spm_spi_master_tb.sv
`timescale 1ns/1ns
module spm_spi_master_tb;
    import spm_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, sclk, sdo, sdi, char_irq, s_cs_n;
    logic [3:0]  ssel;
    logic        s_cpol = 1'b0;
    logic        s_cpha = 1'b0;
    logic        s_hi = 1'b0;
    logic        s_on = 1'b0;
    logic [1:0]  s_sel = 2'h0;
    logic [31:0] s_tx = 32'h0;
    logic [31:0] s_rx;
    logic [31:0] lfsr_q = 32'hC8DB_A602;
    logic [64:0] note;
    logic [64:0] rd_q[$];
    logic [31:0] sl_q[$];
    int          irq_due = 0;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    always #10 pclk = ~pclk;
    // model deselected while selects are reconfigured, no false frames
    assign s_cs_n = s_on ? ssel[s_sel] ^ s_hi : 1'b1;
    spm_spi_master i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock_out(sclk),
        .serial_data_out(sdo), .serial_data_in(sdi),
        .slave_select_out(ssel), .char_irq(char_irq)
    );
    spm_slave_model i_slave (
        .sclk(sclk), .cs_n(s_cs_n), .mosi(sdo), .cpol(s_cpol),
        .cpha(s_cpha), .tx_word(s_tx), .miso(sdi), .rx_word(s_rx)
    );
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [13:0] i,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {i, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] i, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, i, d, r);
    endtask
    task automatic rd(input logic [13:0] i, input logic [31:0] e, m,
                      output logic [31:0] r);
        rd_q.push_back({1'b0, m, e});
        apb(1'b0, i, 32'h0, r);
    endtask
    // one frame: program, start, wait, read back the last character
    task automatic xfer(input logic [1:0] sel, md, dly, input logic hi, lp,
                        irq, input int len, nch, input logic [15:0] div);
        spm_sel_cfg_t c;
        logic [31:0]  d, sw, ex, rc, r;
        s_on = 1'b0;
        c = '{dly, hi, md[1], md[0]};
        lfsr_q = lfsr(lfsr_q);
        d = lfsr_q >> (32 - len);
        lfsr_q = lfsr(lfsr_q);
        sw = lfsr_q;
        s_tx = sw;
        ex = 32'h0;
        repeat (nch) begin
            ex = (ex << len) | d;
            rc = sw >> (32 - len);
            sw = sw << len;
        end
        wr(SPM_IDX_CLK_DIV, {16'h0, div});
        wr(SPM_IDX_CLK_CTL, {31'h0, lp});
        wr(sel[1] ? SPM_IDX_SEL_HI : SPM_IDX_SEL_LO,
           32'(c) << (8 * sel[0]));
        wr(SPM_IDX_CMD_LO, 32'(nch - 1) | 32'(irq) << SPM_CMD_IRQ_BIT);
        wr(SPM_IDX_CMD_HI, 32'(len - 1) | 32'(sel) << SPM_CMD_SEL_LSB);
        wr(SPM_IDX_DAT_LO, d & 32'hFFFF);
        wr(SPM_IDX_DAT_HI, d >> 16);
        cmp("sclk_idle", 32'(md[1]), 32'(sclk));
        {s_sel, s_hi, s_cpol, s_cpha} = {sel, hi, md};
        s_on = 1'b1;
        sl_q.push_back(ex);
        irq_due += irq ? nch : 0;
        wr(SPM_IDX_CMD_HI, 32'(len - 1) | 32'(sel) << SPM_CMD_SEL_LSB
           | 32'h8000);
        rd(SPM_IDX_STAT_LO, 32'h1, 32'h1, r);
        do rd(SPM_IDX_STAT_LO, 32'h0, 32'h0, r);
        while (r[0] !== 1'b0);
        rc = lp ? d : rc;
        rd(SPM_IDX_DAT_LO, rc & 32'hFFFF, '1, r);
        rd(SPM_IDX_DAT_HI, rc >> 16, '1, r);
        cmp("irq_left", 32'h0, 32'(irq_due));
    endtask
    // read results against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            note = rd_q.pop_front();
            cmp("prdata", note[31:0] & note[63:32], prdata & note[63:32]);
            cmp("pslverr", 32'(note[64]), 32'(pslverr));
        end
    end
    // slave's bits at each frame end; irq pulses against the count due
    always @(posedge s_cs_n) begin
        if (sl_q.size() > 0) cmp("slave_rx", sl_q.pop_front(), s_rx);
    end
    always @(posedge pclk) begin
        cycles++;
        if (char_irq === 1'b1) irq_due--;
        if (cycles == 60000) begin
            failures++;
            print_verdict;
        end
    end
    initial begin
        logic [31:0] r;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, a read-only write and an unmapped read
        for (int i = 0; i < 10; i++) rd(SPM_IDX_CLK_DIV + 14'(i), 0, '1, r);
        wr(SPM_IDX_STAT_HI, '1);
        rd(SPM_IDX_STAT_HI, 32'h0, '1, r);
        rd_q.push_back({1'b1, 32'hFFFF_FFFF, 32'h0});
        apb(1'b0, 14'h300A, 32'h0, r);
        lfsr_q = lfsr(lfsr_q);
        wr(SPM_IDX_CLK_DIV, lfsr_q & 32'hFFFF);
        rd(SPM_IDX_CLK_DIV, lfsr_q & 32'hFFFF, '1, r);
        xfer(2'd0, 2'd0, 2'd0, 1'b0, 1'b0, 1'b1, 8, 1, 16'h0004);
        xfer(2'd1, 2'd1, 2'd1, 1'b0, 1'b0, 1'b1, 1, 3, 16'h0003);
        xfer(2'd2, 2'd2, 2'd3, 1'b1, 1'b0, 1'b0, 32, 1, 16'h0005);
        xfer(2'd3, 2'd3, 2'd2, 1'b0, 1'b1, 1'b1, 13, 2, 16'h0000);
        xfer(2'd0, 2'd0, 2'd0, 1'b0, 1'b0, 1'b0, 1, 4096, 16'h0001);
        print_verdict;
    end
endmodule // spm_spi_master_tb
